// [design/drsseq_sequencer.sv]
`timescale 1ns/10ps
// Summary of operation
// - normal: system plus core reset, vector catch
// - any link mode; every strategy ends halted
// - register reset fault: pin, then connect-under-reset
// - strategy 1 resets core only
// - strategy 1 core reset waits sticky status high then low
// - arm vector catch before core or pin reset, except strategy 4, which sets a boot breakpoint instead; strategy 3 arms it during pin reset
// - strategy 2 drives reset output low
// - strategy 3 holds reset while connecting
// - strategy 4 halts right after bootloader
// - strategy 5 halts before bootloader runs
// - strategy 6 normal reset then watchdog off
// - strategy 7 system reset, halt after kernel
// - strategy 8 system reset with vector catch
// - strategy 9 halt after boot, watchdog off
// - strategy 10 vector catch, then watchdog off
module drsseq_sequencer
	import drsseq_pkg::*;
#(
	parameter int POLL_LIMIT = 1000
) (
	input  wire logic              i_clock,
	input  wire logic              i_rstn,
	input  wire logic              i_link_clock,
	input  wire logic              i_start,
	input  wire logic [STRAT_W-1:0] i_strategy,
	input  wire logic              i_swd_mode,
	input  wire logic              i_swd_fast,
	input  wire logic              i_target_reset_n,
	input  wire logic              i_link_ack,
	input  wire drs_resp_s         i_link_resp,
	output logic                   o_busy,
	output logic                   o_done,
	output logic                   o_fail,
	output logic                   o_bad_strategy,
	output logic                   o_halted,
	output logic                   o_slow_link,
	output logic [1:0]             o_fallback,
	output logic                   o_reset_pin_n,
	output logic                   o_link_req,
	output drs_op_s                o_link_op
);

	// poll counter is 16 bits wide
	if (POLL_LIMIT < 1 || POLL_LIMIT > 65535) begin : g_poll_check
		$error("POLL_LIMIT out of range");
	end

	typedef enum logic [10:0] {
		ST_IDLE      = 11'h001,
		ST_BP        = 11'h002,
		ST_VC        = 11'h004,
		ST_RST       = 11'h008,
		ST_PIN_ON    = 11'h010,
		ST_PIN_OFF   = 11'h020,
		ST_STICKY_HI = 11'h040,
		ST_STICKY_LO = 11'h080,
		ST_HALT      = 11'h100,
		ST_WDOG      = 11'h200,
		ST_DONE      = 11'h400
	} drs_state_e;

	function automatic drs_plan_s plan_of(input logic [STRAT_W-1:0] s);
		drs_plan_s p;
		p       = '0;
		p.valid = 1'b1;
		case (s)
			STRAT_NORMAL, STRAT_BOOT_SKIP: begin
				p.vc   = 1'b1;
				p.sys  = 1'b1;
				p.core = 1'b1;
			end
			STRAT_CORE: begin
				p.vc     = 1'b1;
				p.core   = 1'b1;
				p.sticky = 1'b1;
			end
			STRAT_PIN: begin
				p.vc  = 1'b1;
				p.pin = 1'b1;
			end
			STRAT_CUR: begin
				p.pin = 1'b1;
				p.cur = 1'b1;
			end
			STRAT_BOOT_RUN: begin
				p.bp   = 1'b1;
				p.sys  = 1'b1;
				p.core = 1'b1;
			end
			STRAT_WDOG_NORM: begin
				p.vc   = 1'b1;
				p.sys  = 1'b1;
				p.core = 1'b1;
				p.wdog = 1'b1;
			end
			STRAT_KERNEL: begin
				p.bp  = 1'b1;
				p.sys = 1'b1;
			end
			STRAT_SYS: begin
				p.vc  = 1'b1;
				p.sys = 1'b1;
			end
			STRAT_BOOT_WDOG: begin
				p.bp   = 1'b1;
				p.sys  = 1'b1;
				p.wdog = 1'b1;
			end
			STRAT_VC_WDOG: begin
				p.vc   = 1'b1;
				p.sys  = 1'b1;
				p.wdog = 1'b1;
			end
			default: p.valid = 1'b0;
		endcase
		return p;
	endfunction

	drs_state_e          state_r;
	drs_plan_s           plan_r;
	logic [1:0]          fb_r;
	logic                busy_r;
	logic [TIMER_W-1:0]  timer_r;
	logic [15:0]         poll_r;
	drs_op_s             op_r;
	logic                req_tgl_r;
	logic                done_s1_r;
	logic                done_s2_r;
	logic                done_s3_r;
	logic                rst_s1_r;
	logic                rst_s2_r;
	logic                done_evt;
	logic                need_op;
	logic                issue;
	logic                op_tmo;
	logic                fail_now;
	drs_plan_s           new_plan;
	drs_resp_s           resp_l_r;
	drs_op_e             op_code;

	// link side
	logic                l_req_s1_r;
	logic                l_req_s2_r;
	logic                l_req_s3_r;
	logic                l_done_tgl_r;

	assign done_evt = done_s2_r ^ done_s3_r;
	assign need_op  = state_r inside {ST_BP, ST_VC, ST_RST, ST_HALT,
		ST_STICKY_HI, ST_STICKY_LO, ST_WDOG};
	// no op may leave on the cycle that abandons the step
	assign issue    = need_op && !busy_r && !fail_now;
	assign op_tmo   = busy_r &&
		(timer_r == TIMER_W'(OP_TIMEOUT_CYC));
	assign fail_now = (done_evt && resp_l_r.fault) || op_tmo ||
		(state_r inside {ST_HALT, ST_STICKY_HI, ST_STICKY_LO} &&
		poll_r == 16'(POLL_LIMIT));
	assign new_plan = plan_of(i_strategy);

	always_comb begin
		case (state_r)
			ST_BP:   op_code = OP_BOOT_BP;
			ST_VC:   op_code = OP_VC_ARM;
			ST_RST:  op_code = OP_RESET;
			ST_WDOG: op_code = OP_WDOG_OFF;
			default: op_code = OP_RD_STATUS;
		endcase
	end

	// target reset pin (from outside) and link-domain done toggle both cross into the probe clock
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_s1_r  <= 1'b1;
			rst_s2_r  <= 1'b1;
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
			done_s3_r <= 1'b0;
		end else begin
			rst_s1_r  <= i_target_reset_n;
			rst_s2_r  <= rst_s1_r;
			done_s1_r <= l_done_tgl_r;
			done_s2_r <= done_s1_r;
			done_s3_r <= done_s2_r;
		end
	end

	// op stays stable until done returns, so link may sample it late
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			op_r      <= '0;
			req_tgl_r <= 1'b0;
			busy_r    <= 1'b0;
		end else if (issue) begin
			op_r.code                     <= op_code;
			op_r.system_reset_request_bit <= plan_r.sys;
			op_r.core_local_reset_bit     <= plan_r.core;
			op_r.swd_mode                 <= i_swd_mode;
			req_tgl_r                     <= ~req_tgl_r;
			busy_r                        <= 1'b1;
		end else if (done_evt || op_tmo || state_r == ST_IDLE) begin
			busy_r    <= 1'b0;
		end
	end

	// one timer: pin hold time or op timeout
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			timer_r <= '0;
		else if (issue || state_r == ST_IDLE || done_evt || fail_now)
			timer_r <= '0;
		else if (busy_r || state_r == ST_PIN_ON)
			timer_r <= timer_r + TIMER_W'(1);
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r        <= ST_IDLE;
			plan_r         <= '0;
			fb_r           <= FB_NONE;
			poll_r         <= '0;
			o_busy         <= 1'b0;
			o_done         <= 1'b0;
			o_fail         <= 1'b0;
			o_bad_strategy <= 1'b0;
			o_halted       <= 1'b0;
			o_slow_link    <= 1'b0;
			o_fallback     <= FB_NONE;
			o_reset_pin_n  <= 1'b1;
		end else begin
			o_done <= 1'b0;
			o_busy <= (state_r != ST_IDLE);
			o_fallback <= fb_r;
			if (fail_now) begin
				// register reset failing points to a powered-down core
				o_reset_pin_n <= 1'b1;
				poll_r        <= '0;
				if (fb_r == FB_NONE && !plan_r.pin) begin
					fb_r    <= FB_PIN;
					plan_r  <= plan_of(STRAT_PIN);
					state_r <= ST_VC;
				end else if (fb_r == FB_PIN) begin
					fb_r    <= FB_CUR;
					plan_r  <= plan_of(STRAT_CUR);
					state_r <= ST_PIN_ON;
				end else begin
					o_fail  <= 1'b1;
					state_r <= ST_IDLE;
				end
			end else begin
				case (state_r)
					ST_IDLE: begin
						if (i_start) begin
							plan_r         <= new_plan;
							fb_r           <= FB_NONE;
							poll_r         <= '0;
							o_fail         <= 1'b0;
							o_halted       <= 1'b0;
							o_bad_strategy <= !new_plan.valid;
							// halt-before-watchdog race needs a fast link
							o_slow_link    <= i_strategy == STRAT_BOOT_WDOG &&
								i_swd_mode && !i_swd_fast;
							if (!new_plan.valid)
								o_fail  <= 1'b1;
							else if (new_plan.bp)
								state_r <= ST_BP;
							else if (new_plan.cur)
								state_r <= ST_PIN_ON;
							else if (new_plan.vc)
								state_r <= ST_VC;
							else
								state_r <= ST_RST;
						end
					end
					ST_BP: if (done_evt) state_r <= ST_RST;
					ST_VC: begin
						if (done_evt) begin
							if (plan_r.cur)
								state_r <= ST_PIN_OFF;
							else if (plan_r.pin)
								state_r <= ST_PIN_ON;
							else
								state_r <= ST_RST;
						end
					end
					ST_RST: begin
						if (done_evt)
							state_r <= plan_r.sticky ? ST_STICKY_HI : ST_HALT;
					end
					ST_PIN_ON: begin
						o_reset_pin_n <= 1'b0;
						if (timer_r >= TIMER_W'(PIN_HOLD_CYC)) begin
							if (plan_r.cur)
								state_r <= ST_VC;
							else if (!rst_s2_r)
								state_r <= ST_PIN_OFF;
							else begin
								// target reset did not follow, count as failure
								poll_r  <= 16'(POLL_LIMIT);
								state_r <= ST_HALT;
							end
						end
					end
					ST_PIN_OFF: begin
						o_reset_pin_n <= 1'b1;
						state_r       <= ST_HALT;
					end
					ST_STICKY_HI: begin
						if (done_evt) begin
							poll_r <= poll_r + 16'h0001;
							if (resp_l_r.reset_sticky_status) begin
								poll_r  <= '0;
								state_r <= ST_STICKY_LO;
							end
						end
					end
					ST_STICKY_LO: begin
						if (done_evt) begin
							poll_r <= poll_r + 16'h0001;
							if (!resp_l_r.reset_sticky_status) begin
								poll_r  <= '0;
								state_r <= ST_HALT;
							end
						end
					end
					ST_HALT: begin
						if (done_evt) begin
							poll_r <= poll_r + 16'h0001;
							if (resp_l_r.halted) begin
								poll_r  <= '0;
								state_r <= plan_r.wdog ? ST_WDOG : ST_DONE;
							end
						end
					end
					ST_WDOG: if (done_evt) state_r <= ST_DONE;
					ST_DONE: begin
						o_halted <= 1'b1;
						o_done   <= 1'b1;
						state_r  <= ST_IDLE;
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// link domain: request toggle in, response and done toggle out
	always_ff @(posedge i_link_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			l_req_s1_r <= 1'b0;
			l_req_s2_r <= 1'b0;
			l_req_s3_r <= 1'b0;
		end else begin
			l_req_s1_r <= req_tgl_r;
			l_req_s2_r <= l_req_s1_r;
			l_req_s3_r <= l_req_s2_r;
		end
	end

	always_ff @(posedge i_link_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_link_req   <= 1'b0;
			o_link_op    <= '0;
			resp_l_r     <= '0;
			l_done_tgl_r <= 1'b0;
		end else if (l_req_s2_r ^ l_req_s3_r) begin
			o_link_op  <= op_r;
			o_link_req <= 1'b1;
		end else if (o_link_req && i_link_ack) begin
			resp_l_r     <= i_link_resp;
			o_link_req   <= 1'b0;
			l_done_tgl_r <= ~l_done_tgl_r;
		end
	end

endmodule

// [design/drsseq_pkg.sv]
package drsseq_pkg;

	localparam int          STRAT_W          = 4;
	localparam logic [3:0]  STRAT_NORMAL     = 4'h0;
	localparam logic [3:0]  STRAT_CORE       = 4'h1;
	localparam logic [3:0]  STRAT_PIN        = 4'h2;
	localparam logic [3:0]  STRAT_CUR        = 4'h3;
	localparam logic [3:0]  STRAT_BOOT_RUN   = 4'h4;
	localparam logic [3:0]  STRAT_BOOT_SKIP  = 4'h5;
	localparam logic [3:0]  STRAT_WDOG_NORM  = 4'h6;
	localparam logic [3:0]  STRAT_KERNEL     = 4'h7;
	localparam logic [3:0]  STRAT_SYS        = 4'h8;
	localparam logic [3:0]  STRAT_BOOT_WDOG  = 4'h9;
	localparam logic [3:0]  STRAT_VC_WDOG    = 4'hA;

	// fallback levels after a failed register reset
	localparam logic [1:0]  FB_NONE          = 2'h0;
	localparam logic [1:0]  FB_PIN           = 2'h1;
	localparam logic [1:0]  FB_CUR           = 2'h2;

	// timing at the 40 ns probe clock
	localparam int          CLK_PERIOD_NS    = 40;
	localparam int          PIN_HOLD_NS      = 1000;
	localparam int          PIN_HOLD_CYC     =
		(PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          OP_TIMEOUT_CYC   = 4000;
	localparam int          TIMER_W          = 12;

	// debug operations handed to the link side
	typedef enum logic [2:0] {
		OP_VC_ARM    = 3'h0,
		OP_BOOT_BP   = 3'h1,
		OP_RESET     = 3'h2,
		OP_RD_STATUS = 3'h3,
		OP_WDOG_OFF  = 3'h4
	} drs_op_e;

	// reset bits go to interrupt_reset_control_reg
	typedef struct packed {
		drs_op_e code;
		logic    system_reset_request_bit;
		logic    core_local_reset_bit;
		logic    swd_mode;
	} drs_op_s;

	// status of debug_halt_control_status_reg plus access fault
	typedef struct packed {
		logic fault;
		logic halted;
		logic reset_sticky_status;
	} drs_resp_s;

	typedef struct packed {
		logic valid;
		logic vc;
		logic bp;
		logic sys;
		logic core;
		logic pin;
		logic cur;
		logic sticky;
		logic wdog;
	} drs_plan_s;

endpackage

// [tb/drsseq_props.sv]
`timescale 1ns/10ps
module drsseq_props
	import drsseq_pkg::*;
#(
	parameter int POLL_LIMIT = 1000
) (
	input wire logic       i_clock,
	input wire logic       i_rstn,
	input wire logic       i_link_clock,
	input wire logic [3:0] i_strategy,
	input wire logic       i_swd_mode,
	input wire logic       i_link_ack,
	input wire logic       o_busy,
	input wire logic       o_done,
	input wire logic       o_fail,
	input wire logic       o_bad_strategy,
	input wire logic       o_halted,
	input wire logic       o_reset_pin_n,
	input wire logic       o_link_req,
	input wire drs_op_s    o_link_op
);
	logic [5:0] low_cnt_r;
	logic       rst_op;

	assign rst_op = o_link_req && o_link_op.code == OP_RESET;

	// saturates so a stuck pin cannot wrap back under the minimum
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			low_cnt_r <= 6'h00;
		else if (o_reset_pin_n)
			low_cnt_r <= 6'h00;
		else if (low_cnt_r != 6'h3F)
			low_cnt_r <= low_cnt_r + 6'h01;
	end

	sequence s_req_waiting;
		o_link_req && !i_link_ack;
	endsequence

	sequence s_req_held;
		o_link_req && $stable(o_link_op);
	endsequence

	chk_bad_sel_fail: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_bad_strategy |-> o_fail) else $error("bad selector without fail");
	chk_done_single: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_done |=> !o_done) else $error("done longer than one cycle");
	chk_done_halted: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_done |-> ##[0:1] o_halted) else $error("done without halt");
	chk_done_no_fail: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_done |-> !o_fail) else $error("done and fail together");
	chk_pin_hold_time: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$rose(o_reset_pin_n) |-> low_cnt_r >= 6'h19) else $error("reset pulse short");
	chk_link_req_held: assert property (@(posedge i_link_clock) disable iff (!i_rstn)
		s_req_waiting |=> s_req_held) else $error("request dropped before ack");
	chk_core_only_bits: assert property (@(posedge i_link_clock) disable iff (!i_rstn)
		rst_op && i_strategy == STRAT_CORE |-> o_link_op.core_local_reset_bit
		&& !o_link_op.system_reset_request_bit) else $error("core reset bits wrong");
	chk_sys_only_bits: assert property (@(posedge i_link_clock) disable iff (!i_rstn)
		rst_op && i_strategy >= STRAT_KERNEL |-> o_link_op.system_reset_request_bit
		&& !o_link_op.core_local_reset_bit) else $error("system reset bits wrong");
	chk_normal_bits: assert property (@(posedge i_link_clock) disable iff (!i_rstn)
		rst_op && i_strategy == STRAT_NORMAL |-> o_link_op.core_local_reset_bit
		&& o_link_op.system_reset_request_bit) else $error("normal reset bits wrong");
	chk_cur_pin_held: assert property (@(posedge i_link_clock) disable iff (!i_rstn)
		o_link_req && o_link_op.code == OP_VC_ARM && i_strategy == STRAT_CUR && o_busy
		|-> !o_reset_pin_n) else $error("pin released while connecting");
	chk_swd_copy: assert property (@(posedge i_link_clock) disable iff (!i_rstn)
		o_link_req |-> o_link_op.swd_mode == i_swd_mode) else $error("link mode lost");
endmodule

bind drsseq_sequencer drsseq_props #(.POLL_LIMIT(POLL_LIMIT)) u_drsseq_props (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_link_clock(i_link_clock),
	.i_strategy(i_strategy), .i_swd_mode(i_swd_mode), .i_link_ack(i_link_ack),
	.o_busy(o_busy), .o_done(o_done), .o_fail(o_fail), .o_halted(o_halted),
	.o_bad_strategy(o_bad_strategy), .o_reset_pin_n(o_reset_pin_n),
	.o_link_req(o_link_req), .o_link_op(o_link_op));

// [tb/drsseq_target_model.sv]
`timescale 1ns/10ps
module drsseq_target_model
	import drsseq_pkg::*;
(
	input  wire logic  i_link_clock,
	input  wire logic  i_rstn,
	input  wire logic  i_req,
	input  wire drs_op_s i_op,
	input  wire logic  i_pin_n,
	input  wire logic  i_clr,
	input  wire logic  i_fault,
	input  wire logic  i_dead,
	input  wire logic  i_slow,
	output logic       o_ack,
	output drs_resp_s  o_resp,
	output logic       o_target_reset_n,
	output logic [11:0] o_hist,
	output logic [1:0] o_rbits,
	output logic [3:0] o_nrd,
	output logic       o_pin_seen,
	output logic       o_vc_pin
);
	logic [2:0] wait_r;
	logic       sticky_r;
	logic       take;
	logic       flt;

	// a dead reset trace floats high on the target pull-up
	assign o_target_reset_n = i_dead ? 1'b1 : i_pin_n;
	assign take = i_req && !o_ack && wait_r == (i_slow ? 3'h5 : 3'h1);
	assign flt = i_fault && i_op.code == OP_RESET;

	always_ff @(posedge i_link_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ack <= 1'b0;
			wait_r <= 3'h0;
			sticky_r <= 1'b0;
			o_resp <= 3'h0;
		end else begin
			o_ack <= take;
			wait_r <= (i_req && !o_ack && !take) ? wait_r + 3'h1 : 3'h0;
			// outside an answer the lines toggle each cycle between the last status and its inverse
			o_resp <= take ? {flt, !flt, i_op.code == OP_RD_STATUS && sticky_r}
				: ~o_resp;
			if (take && i_op.code == OP_RESET && i_op.core_local_reset_bit && !flt)
				sticky_r <= 1'b1;
			else if (take && i_op.code == OP_RD_STATUS)
				sticky_r <= 1'b0;
		end
	end

	always_ff @(posedge i_link_clock) begin
		if (i_clr) begin
			o_hist <= 12'h000;
			o_rbits <= 2'h0;
			o_nrd <= 4'h0;
			o_pin_seen <= 1'b0;
			o_vc_pin <= 1'b1;
		end else begin
			if (!i_pin_n)
				o_pin_seen <= 1'b1;
			if (take && i_op.code == OP_RD_STATUS)
				o_nrd <= o_nrd + 4'h1;
			else if (take)
				o_hist <= {o_hist[8:0], i_op.code + 3'h1};
			if (take && i_op.code == OP_RESET)
				o_rbits <= {i_op.system_reset_request_bit, i_op.core_local_reset_bit};
			if (take && i_op.code == OP_VC_ARM)
				o_vc_pin <= i_pin_n;
		end
	end
endmodule

// [tb/tb_drsseq_sequencer.sv]
`timescale 1ns/10ps
module tb_drsseq_sequencer;
	import drsseq_pkg::*;
	logic i_clock = 0, i_link_clock = 1, i_rstn = 0, i_start = 0;
	logic [3:0] i_strategy = 4'h0;
	logic i_swd_mode = 0, i_swd_fast = 0, clr = 1, fault = 0, dead = 0;
	logic slow = 0, tgt_rst_n, ack, busy, done, fail, bad, halted, slow_lnk;
	logic pin_n, req, pin_seen, vc_pin;
	logic [1:0] fallback, rbits;
	logic [3:0] nrd;
	logic [11:0] hist;
	drs_resp_s resp;
	drs_op_s op;
	int failures = 0;
	int tests_run = 0;
	localparam logic [11:0] EXP_HIST [11] = '{12'h00B, 12'h00B, 12'h001,
		12'h001, 12'h013, 12'h00B, 12'h05D, 12'h013, 12'h00B, 12'h09D, 12'h05D};
	localparam logic [1:0] EXP_RB [11] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h3,
		2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2};

	always #20 i_clock = ~i_clock;
	always #16 i_link_clock = ~i_link_clock;

	drsseq_sequencer #(.POLL_LIMIT(8)) u_drsseq_sequencer (.i_clock(i_clock),
		.i_rstn(i_rstn), .i_link_clock(i_link_clock), .i_start(i_start),
		.i_strategy(i_strategy), .i_swd_mode(i_swd_mode), .i_swd_fast(i_swd_fast),
		.i_target_reset_n(tgt_rst_n), .i_link_ack(ack), .i_link_resp(resp),
		.o_busy(busy), .o_done(done), .o_fail(fail), .o_bad_strategy(bad),
		.o_halted(halted), .o_slow_link(slow_lnk), .o_fallback(fallback),
		.o_reset_pin_n(pin_n), .o_link_req(req), .o_link_op(op));

	drsseq_target_model u_drsseq_target_model (.i_link_clock(i_link_clock),
		.i_rstn(i_rstn), .i_req(req), .i_op(op), .i_pin_n(pin_n), .i_clr(clr),
		.i_fault(fault), .i_dead(dead), .i_slow(slow), .o_ack(ack),
		.o_resp(resp), .o_target_reset_n(tgt_rst_n), .o_hist(hist),
		.o_rbits(rbits), .o_nrd(nrd), .o_pin_seen(pin_seen), .o_vc_pin(vc_pin));

	task automatic check(input string nm, input logic [11:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic run(input logic [3:0] s, output logic ok);
		ok = 1'b0;
		i_strategy <= s;
		i_swd_mode <= s[0];
		i_swd_fast <= s[1];
		slow <= s[2];
		clr <= 1'b1;
		repeat (2) @(posedge i_clock);
		clr <= 1'b0;
		i_start <= 1'b1;
		@(posedge i_clock);
		i_start <= 1'b0;
		for (int n = 0; n < 5000; n++) begin
			@(posedge i_clock);
			if (done === 1'b1)
				ok = 1'b1;
			if (done === 1'b1 || fail === 1'b1)
				break;
		end
		repeat (2) @(posedge i_clock);
	endtask

	task automatic test_bad;
		logic ok;
		for (int i = 0; i < 2; i++) begin
			run(i ? 4'hF : 4'hB, ok);
			check("bad done", ok, 1'b0);
			check("bad flag", {fail, bad}, 2'h3);
		end
	endtask

	task automatic test_all;
		logic ok;
		for (int s = 0; s <= 10; s++) begin
			run(4'(s), ok);
			check("done", {ok, halted}, 2'h3);
			check("no fail", {busy, fail, bad, fallback}, 5'h00);
			check("op trace", hist, EXP_HIST[s]);
			check("reset bits", rbits, EXP_RB[s]);
			check("pin used", pin_seen, s == 2 || s == 3);
			check("pin at catch", vc_pin, s != 3);
			check("slow link", slow_lnk, s == 9);
			if (s == 1)
				check("status polls", nrd, 4'h3);
		end
	endtask

	task automatic test_faults;
		logic ok;
		dead <= 1'b1;
		run(STRAT_PIN, ok);
		dead <= 1'b0;
		check("dead pin", {ok, fail, fallback}, 4'h4);
		fault <= 1'b1;
		run(STRAT_SYS, ok);
		fault <= 1'b0;
		check("retry pin", {ok, halted, fallback, pin_seen}, 5'h1B);
		// both register and pin reset fail: connect under reset
		dead <= 1'b1;
		fault <= 1'b1;
		run(STRAT_SYS, ok);
		dead <= 1'b0;
		fault <= 1'b0;
		check("retry cur", {ok, halted, fallback, vc_pin}, 5'h1C);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#2000000;
		failures++;
		end_of_test();
	end

	initial begin
		repeat (3) @(posedge i_clock);
		i_rstn <= 1'b1;
		test_bad();
		test_all();
		test_faults();
		end_of_test();
	end
endmodule
